// ===== verilog/incr_skip_or_literal_exec.sv
`timescale 1ns/1ns
`default_nettype none
`include "incr_defines.svh"
module incr_skip_or_literal_exec
    import incr_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic I_INSTR_VALID,
    input wire logic [11:0] I_INSTR,
    input wire logic [7:0] I_FILE_DATA,
    output logic [7:0] O_ACC,
    output logic O_ZERO,
    output logic O_FILE_WR,
    output logic [4:0] O_FILE_ADDR,
    output logic [7:0] O_FILE_DATA,
    output logic O_CLAIMED,
    output logic O_SKIP_TAKEN,
    output logic O_NOP_EXEC
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    decode_if dec ();

    assign dec.instr = I_INSTR;

    incr_decode u_decode (
        .dec(dec)
    );

    // ----------------------------------------------------------------
    // Datapath
    // ----------------------------------------------------------------
    byte_t sum;
    byte_t or_result;
    logic sum_zero;
    logic skip_pending;
    logic live;

    // The 8-bit target drops the carry, giving wrap modulo 256.
    assign sum = 8'(I_FILE_DATA + 8'h01);
    assign sum_zero = (sum == 8'h00);
    assign or_result = O_ACC | dec.literal;
    // A word arriving while a skip is pending is discarded, never executed.
    assign live = I_INSTR_VALID && !skip_pending;

    // ----------------------------------------------------------------
    // Skip tracking
    // ----------------------------------------------------------------
    // The fetched word after a zero result becomes a no-operation, which
    // makes the skipping instruction cost a second cycle.
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            skip_pending <= 1'b0;
        end else if (I_INSTR_VALID && skip_pending) begin
            skip_pending <= 1'b0;
        end else if (live && dec.op == OP_INCREMENT_SKIP_ZERO) begin
            skip_pending <= sum_zero;
        end
    end

    // Pulses that report a skip being armed and the no-operation run.
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_SKIP_TAKEN <= 1'b0;
            O_NOP_EXEC <= 1'b0;
        end else begin
            O_SKIP_TAKEN <= live && dec.op == OP_INCREMENT_SKIP_ZERO &&
                            sum_zero;
            O_NOP_EXEC <= I_INSTR_VALID && skip_pending;
        end
    end

    // ----------------------------------------------------------------
    // Accumulator
    // ----------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_ACC <= `ACC_RESET;
        end else if (live) begin
            unique case (dec.op)
                OP_INCREMENT_FILE,
                OP_INCREMENT_SKIP_ZERO: begin
                    if (!dec.to_file) begin
                        O_ACC <= sum;
                    end
                end
                OP_OR_LITERAL: begin
                    O_ACC <= or_result;
                end
                OP_OTHER: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Zero flag
    // ----------------------------------------------------------------
    // Increment-skip is deliberately absent: it leaves status untouched.
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_ZERO <= `ZERO_RESET;
        end else if (live && dec.op == OP_INCREMENT_FILE) begin
            O_ZERO <= sum_zero;
        end else if (live && dec.op == OP_OR_LITERAL) begin
            O_ZERO <= (or_result == 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // File register write-back
    // ----------------------------------------------------------------
    // The write is a one-cycle strobe; address and data hold until the
    // next write so the register file may sample them late.
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_FILE_WR <= 1'b0;
            O_FILE_ADDR <= 5'h00;
            O_FILE_DATA <= 8'h00;
        end else begin
            O_FILE_WR <= 1'b0;
            if (live && dec.to_file &&
                (dec.op == OP_INCREMENT_FILE ||
                 dec.op == OP_INCREMENT_SKIP_ZERO)) begin
                O_FILE_WR <= 1'b1;
                O_FILE_ADDR <= dec.addr;
                O_FILE_DATA <= sum;
            end
        end
    end

    // Claim pulse: one of the three handled opcodes was executed.
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_CLAIMED <= 1'b0;
        end else begin
            O_CLAIMED <= live && dec.op != OP_OTHER;
        end
    end

endmodule // incr_skip_or_literal_exec
`default_nettype wire

// ===== verilog/incr_defines.svh
`ifndef INCR_DEFINES_SVH
`define INCR_DEFINES_SVH

// ----------------------------------------------------------------------
// Instruction field layout
// ----------------------------------------------------------------------
`define INSTR_W 12
`define OP6_MSB 11
`define OP6_LSB 6
`define OP4_MSB 11
`define OP4_LSB 8
`define DEST_BIT 5
`define ADDR_MSB 4
`define LIT_MSB 7

// ----------------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------------
`define OPC_INCREMENT_FILE 6'h0A
`define OPC_INCREMENT_SKIP_ZERO 6'h0F
`define OPC_OR_LITERAL 4'hD

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACC_RESET 8'h00
`define ZERO_RESET 1'b0

`endif

// ===== verilog/incr_pkg.sv
package incr_pkg;

    // Operation recognised by the decoder.
    typedef enum logic [1:0] {
        OP_OTHER,
        OP_INCREMENT_FILE,
        OP_INCREMENT_SKIP_ZERO,
        OP_OR_LITERAL
    } op_e;

    typedef logic [7:0] byte_t;

endpackage

// ===== verilog/decode_if.sv
`timescale 1ns/1ns
`default_nettype none
interface decode_if;
    import incr_pkg::*;
    logic [11:0] instr;
    op_e op;
    logic to_file;
    logic [4:0] addr;
    byte_t literal;

    modport decoder (input instr, output op, to_file, addr, literal);
    modport exec (output instr, input op, to_file, addr, literal);
endinterface
`default_nettype wire

// ===== verilog/incr_decode.sv
`timescale 1ns/1ns
`default_nettype none
`include "incr_defines.svh"
module incr_decode
    import incr_pkg::*;
(
    decode_if.decoder dec
);

    // -------------------------------------------------------------
    // Opcode match
    // -------------------------------------------------------------
    // Pure combinational decode so the executing stage sees the op in the
    // same cycle that the word arrives.
    always_comb begin
        if (dec.instr[`OP6_MSB:`OP6_LSB] == `OPC_INCREMENT_FILE) begin
            dec.op = OP_INCREMENT_FILE;
        end else if (dec.instr[`OP6_MSB:`OP6_LSB] ==
                     `OPC_INCREMENT_SKIP_ZERO) begin
            dec.op = OP_INCREMENT_SKIP_ZERO;
        end else if (dec.instr[`OP4_MSB:`OP4_LSB] == `OPC_OR_LITERAL) begin
            dec.op = OP_OR_LITERAL;
        end else begin
            dec.op = OP_OTHER;
        end
    end

    // Operand fields.
    assign dec.to_file = dec.instr[`DEST_BIT];
    assign dec.addr = dec.instr[`ADDR_MSB:0];
    assign dec.literal = dec.instr[`LIT_MSB:0];

endmodule // incr_decode
`default_nettype wire

// ===== tb/incr_exec_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module incr_exec_assertions (
    input wire logic I_SYS_CLK,
    input wire logic I_RESET,
    input wire logic I_INSTR_VALID,
    input wire logic [11:0] I_INSTR,
    input wire logic [7:0] I_FILE_DATA,
    input wire logic [7:0] O_ACC,
    input wire logic O_ZERO,
    input wire logic O_FILE_WR,
    input wire logic [4:0] O_FILE_ADDR,
    input wire logic [7:0] O_FILE_DATA,
    input wire logic O_CLAIMED,
    input wire logic O_SKIP_TAKEN,
    input wire logic O_NOP_EXEC
);
    // A skip stays owed over idle cycles until a valid word is eaten.
    logic pend, live, go, inf, ins, orl;
    logic [7:0] sum;
    assign live = O_SKIP_TAKEN || pend;
    assign go = I_INSTR_VALID && !live;
    assign inf = go && I_INSTR[11:6] == 6'h0A;
    assign ins = go && I_INSTR[11:6] == 6'h0F;
    assign orl = go && I_INSTR[11:8] == 4'hD;
    assign sum = I_FILE_DATA + 8'h01;
    always_ff @(posedge I_SYS_CLK or posedge I_RESET) begin
        if (I_RESET) pend <= 1'b0;
        else pend <= live && !I_INSTR_VALID;
    end
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);
    sequence s_zero_skip;
        ins && sum == 8'h00 ##1 I_INSTR_VALID;
    endsequence
    a_increment_file_file: assert property (inf && I_INSTR[5] |=> O_FILE_WR
        && O_FILE_DATA == $past(sum) && O_FILE_ADDR == $past(I_INSTR[4:0]))
        else $error("increment to file wrong");
    a_increment_file_acc: assert property (inf && !I_INSTR[5] |=> !O_FILE_WR
        && O_ACC == $past(sum)) else $error("increment to acc wrong");
    a_increment_file_zero: assert property (inf |=>
        O_ZERO == ($past(sum) == 8'h00)) else $error("zero flag wrong");
    a_skip_status: assert property (ins |=> $stable(O_ZERO) &&
        O_SKIP_TAKEN == ($past(sum) == 8'h00)) else $error("skip wrong");
    a_discard_nop: assert property (I_INSTR_VALID && live |=>
        O_NOP_EXEC && !O_CLAIMED) else $error("word not discarded");
    a_skip_cycles: assert property (s_zero_skip |=>
        O_NOP_EXEC && !O_FILE_WR) else $error("no second cycle");
    a_or_result: assert property (orl |=>
        O_ACC == ($past(O_ACC) | $past(I_INSTR[7:0])))
        else $error("or result wrong");
    a_or_zero: assert property (orl |=> O_CLAIMED &&
        O_ZERO == (O_ACC == 8'h00)) else $error("or zero flag wrong");
endmodule // incr_exec_assertions
bind incr_skip_or_literal_exec incr_exec_assertions u_chk (.*);
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import incr_pkg::*;
    logic clk = 0, rst = 1, vld = 0;
    logic [11:0] ins = 12'h000;
    byte_t fdi = 8'h00, acc, fdo;
    logic zero, wr, cl, sk, no_operation;
    logic [4:0] fad;
    int mismatches = 0, n_checks = 0, e_acc = 0, e_z = 0, e_wr = 0;
    int e_ad = 0, e_fd = 0, e_cl = 0, e_sk = 0, e_nop = 0, pend = 0, r, i;
    incr_skip_or_literal_exec dut (.I_SYS_CLK(clk), .I_RESET(rst),
        .I_INSTR_VALID(vld), .I_INSTR(ins), .I_FILE_DATA(fdi),
        .O_ACC(acc), .O_ZERO(zero), .O_FILE_WR(wr), .O_FILE_ADDR(fad),
        .O_FILE_DATA(fdo), .O_CLAIMED(cl), .O_SKIP_TAKEN(sk),
        .O_NOP_EXEC(no_operation));
    initial forever #20 clk = ~clk;
    // A hang is cut at well over the 2000 cycles the run needs.
    initial begin
        #150000;
        mismatches++;
        results();
    end
    task automatic chk(input string n, input int e, input logic [7:0] g);
        n_checks++;
        if (g !== 8'(e)) begin
            mismatches++;
            $display("[ERR] %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Random words, biased to the handled opcodes, checked each cycle.
    // --------------------------------------------------------------
    initial begin
        r = $urandom(51322);
        repeat (4) @(negedge clk);
        rst = 0;
        for (i = 0; i < 2000; i++) begin
            @(negedge clk);
            chk("acc", e_acc, acc);
            chk("zero", e_z, {7'h00, zero});
            chk("wr", e_wr, {7'h00, wr});
            chk("addr", e_ad, {3'h0, fad});
            chk("fdata", e_fd, fdo);
            chk("claim", e_cl, {7'h00, cl});
            chk("skip", e_sk, {7'h00, sk});
            chk("nop", e_nop, {7'h00, no_operation});
            vld = $urandom % 5 != 0;
            ins = 12'($urandom);
            r = $urandom % 4;
            if (r == 0) ins[11:6] = 6'h0A;
            if (r == 1) ins[11:6] = 6'h0F;
            if (r == 2) ins[11:8] = 4'hD;
            fdi = ($urandom % 3) != 0 ? 8'($urandom) : 8'hFF;
            e_wr = 0;
            e_cl = 0;
            e_sk = 0;
            e_nop = 0;
            if (vld && pend) begin
                e_nop = 1;
                pend = 0;
            end else if (vld && (ins[11:6] == 6'h0A ||
                                 ins[11:6] == 6'h0F)) begin
                r = (fdi + 1) % 256;
                e_cl = 1;
                if (ins[5]) begin
                    e_wr = 1;
                    e_ad = ins[4:0];
                    e_fd = r;
                end else e_acc = r;
                if (ins[11:6] == 6'h0A) e_z = r == 0;
                else if (r == 0) pend = 1;
                e_sk = ins[11:6] == 6'h0F && r == 0;
            end else if (vld && ins[11:8] == 4'hD) begin
                e_acc = e_acc | ins[7:0];
                e_z = e_acc == 0;
                e_cl = 1;
            end
        end
        results();
    end
endmodule // testbench
`default_nettype wire
